// file: inc/psc_pkg.sv
// Purpose: shared constants and types for the pulse channel counter, current and pid block
// Assumes: one 25 MHz clock, current samples arrive as unsigned microamperes
// Notes:   analog scale is 27648 for nominal full current
package psc_pkg;

    localparam int unsigned CLK_HZ       = 25000000;
    localparam logic [15:0] AN_NOMINAL   = 16'h6C00;  // 27648
    localparam logic [15:0] AN_MAX       = 16'h7EFF;  // 32511
    localparam logic [15:0] CUR_IDLE     = 16'h7FFF;
    localparam logic [15:0] CUR_NONE     = 16'h0000;
    localparam logic [3:0]  SEQ_ZERO     = 4'h0;
    localparam logic [3:0]  SEQ_ONE      = 4'h1;
    localparam logic [3:0]  SEQ_STEP     = 4'h1;
    // sensed-current limits, microamperes
    localparam logic [23:0] NOM_UA_DUAL  = 24'h1E8480; // 2 A
    localparam logic [23:0] NOM_UA_SING  = 24'h3D0900; // 4 A
    localparam logic [23:0] OVC_UA_DUAL  = 24'h242A70; // 2.37 A
    localparam logic [23:0] OVC_UA_SING  = 24'h4854E0; // 4.74 A
    // reference current ceilings, milliamperes
    localparam logic [12:0] REF_MA_DUAL  = 13'h07D0;   // 2000 mA
    localparam logic [12:0] REF_MA_SING  = 13'h0FA0;   // 4000 mA
    localparam logic [23:0] UA_PER_MA    = 24'h0003E8; // 1000

    // operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_PULSE  = 6'h01,
        MODE_PWM    = 6'h02,
        MODE_TRAIN  = 6'h04,
        MODE_ONOFF  = 6'h08,
        MODE_FREQ   = 6'h10,
        MODE_MOTOR  = 6'h20
    } psc_mode_t;

    // input function setting
    typedef enum logic [1:0] {
        DI_INPUT    = 2'h0,
        DI_HW_GATE  = 2'h1,
        DI_EXT_STOP = 2'h2
    } psc_difn_t;

    // controller parameter record
    typedef struct packed {
        logic        enable;
        logic        p_sel;
        logic        i_sel;
        logic        d_sel;
        logic [12:0] ref_ma;
        logic [23:0] dead_ua;
        logic [15:0] hi_lim;
        logic [15:0] lo_lim;
        logic [7:0]  gain_shift_p;
        logic [7:0]  gain_shift_i;
        logic [7:0]  gain_shift_d;
    } psc_pid_cfg_t;

endpackage : psc_pkg

// file: hw/psc_top.sv
// Purpose: sequence counter, mean current report and pid current control of one channel
// Assumes: all inputs synchronous to REF_CLK; current samples in microamperes
// Notes:   duty output is analog scale 0..27648 of the pwm period
//
// What this block does
// [RL1] count completed sequences, good or failed
// [RL2] four bit counter wraps to zero
// [RL3] plain input: counter set to one
// [RL4] hardware gate: increment per completed sequence
// [RL5] on/off delay: count both output edges
// [RL6] pwm, frequency, motor modes: no counting
// [RL7] run enable low clears counter
// [RL8] current only in pwm/train, no high speed
// [RL9] output inactive reports 7FFF
// [RL10] mean over one period, valid after first
// [RL11] dual channel: 2 A reads 27648
// [RL12] single channel: 4 A reads 27648
// [RL13] overcurrent above 2.37 A or 4.74 A
// [RL14] correct only outside dead band, sum parts
// [RL15] clamp to limits, set duty fraction
// [RL16] controller only in pwm, no high speed
// [RL17] disabled controller ignores its parameters
// [RL18] select bits include p, i, d parts
// [RL19] reference up to 4000 or 2000 mA
// [RL20] dead band width is half width
// [RL21] high limit 27648 means full reference
// [RL22] run low or new record clears controller
// [RL23] reported current saturates at 32511
`timescale 1ns/10ps
module psc_top
    import psc_pkg::*;
#(
    parameter int SEQ_W = 4
) (
    input  wire logic               REF_CLK,
    input  wire logic               RESETN,
    input  wire psc_mode_t          OPERATING_MODE,
    input  wire psc_difn_t          INPUT_FUNCTION_SETTING,
    input  wire logic               HIGH_SPEED,
    input  wire logic               SINGLE_CHANNEL,
    input  wire logic               DIAG_ENABLE,
    input  wire logic               SOFTWARE_RUN_ENABLE,
    input  wire logic               OUTPUT_ACTIVE_STATUS,
    input  wire logic               CHANNEL_OUTPUT_A,
    input  wire logic               SEQUENCE_DONE,
    input  wire logic               PERIOD_END,
    input  wire logic               SAMPLE_VALID,
    input  wire logic [23:0]        SAMPLE_UA,
    input  wire psc_pid_cfg_t       PID_CFG,
    input  wire logic               PID_CFG_LOAD,
    input  wire logic [15:0]        SET_POINT,
    output logic [SEQ_W-1:0]        COMPLETED_SEQUENCE_COUNT,
    output logic [15:0]             MEASURED_CURRENT,
    output logic                    OVERCURRENT,
    output logic [15:0]             DUTY_VALUE,
    output logic                    DUTY_AT_HIGH,
    output logic                    DUTY_AT_LOW,
    output logic                    CONTROL_ACTIVE
);

    // reset release through two flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ---- sequence counter ----
    logic [SEQ_W-1:0] seq_q, seq_d;
    logic             out_a_q, out_a_d;

    always_comb begin
        seq_d   = seq_q;
        out_a_d = CHANNEL_OUTPUT_A;
        if (!SOFTWARE_RUN_ENABLE) begin
            seq_d = SEQ_W'(SEQ_ZERO);                                  // RL7
        end else begin
            case (OPERATING_MODE)
                MODE_PULSE, MODE_TRAIN: begin
                    if (SEQUENCE_DONE) begin                           // RL1
                        if (INPUT_FUNCTION_SETTING == DI_HW_GATE)
                            seq_d = seq_q + SEQ_W'(SEQ_STEP);          // RL4 RL2
                        else
                            seq_d = SEQ_W'(SEQ_ONE);                   // RL3
                    end
                end
                MODE_ONOFF: begin
                    if (CHANNEL_OUTPUT_A != out_a_q)
                        seq_d = seq_q + SEQ_W'(SEQ_STEP);              // RL5 RL2
                end
                default: seq_d = seq_q;                                // RL6
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            seq_q   <= '0;
            out_a_q <= 1'b0;
        end else begin
            seq_q   <= seq_d;
            out_a_q <= out_a_d;
        end
    end
    assign COMPLETED_SEQUENCE_COUNT = seq_q;

    // ---- current measurement ----
    logic        meas_ok;
    logic [39:0] acc_q, acc_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] cur_q, cur_d;
    logic        valid_q, valid_d;
    logic        ovc_q, ovc_d;
    logic [23:0] mean_ua;
    logic [39:0] scaled;
    logic [23:0] nom_ua;

    assign meas_ok = (OPERATING_MODE == MODE_PWM || OPERATING_MODE == MODE_TRAIN)
                     && !HIGH_SPEED;                                   // RL8
    assign nom_ua  = SINGLE_CHANNEL ? NOM_UA_SING : NOM_UA_DUAL;      // RL11 RL12
    assign mean_ua = (cnt_q == 16'h0000) ? 24'h000000 : 24'(acc_q / 40'(cnt_q));
    assign scaled  = (40'(mean_ua) * 40'(AN_NOMINAL)) / 40'(nom_ua);  // RL11 RL12

    always_comb begin
        acc_d   = acc_q;
        cnt_d   = cnt_q;
        cur_d   = cur_q;
        valid_d = valid_q;
        ovc_d   = 1'b0;
        if (!meas_ok) begin
            acc_d = '0; cnt_d = '0; valid_d = 1'b0;
            cur_d = CUR_NONE;                                          // RL8
        end else if (!OUTPUT_ACTIVE_STATUS) begin
            acc_d = '0; cnt_d = '0; valid_d = 1'b0;
            cur_d = CUR_IDLE;                                          // RL9
        end else begin
            if (SAMPLE_VALID) begin
                acc_d = acc_q + 40'(SAMPLE_UA);
                cnt_d = cnt_q + 16'h0001;
            end
            if (PERIOD_END) begin                                      // RL10
                valid_d = 1'b1;
                acc_d   = '0;
                cnt_d   = '0;
                if (scaled > 40'(AN_MAX))
                    cur_d = AN_MAX;                                    // RL23
                else
                    cur_d = scaled[15:0];
            end else if (!valid_q) begin
                cur_d = CUR_IDLE;                                      // RL10
            end
            if (DIAG_ENABLE && SAMPLE_VALID)
                ovc_d = SAMPLE_UA > (SINGLE_CHANNEL ? OVC_UA_SING
                                                    : OVC_UA_DUAL);   // RL13
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= '0;
            cnt_q   <= '0;
            cur_q   <= CUR_NONE;
            valid_q <= 1'b0;
            ovc_q   <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            cnt_q   <= cnt_d;
            cur_q   <= cur_d;
            valid_q <= valid_d;
            ovc_q   <= ovc_d;
        end
    end
    assign MEASURED_CURRENT = cur_q;
    assign OVERCURRENT      = ovc_q;

    // ---- pid current controller ----
    psc_pid_cfg_t  cfg_q, cfg_d;
    logic          ctl_on;
    logic [12:0]   ref_lim;
    logic [12:0]   ref_ma;
    logic [15:0]   hi_eff;
    logic signed [31:0] err_ua;
    logic signed [31:0] dead_s;
    logic signed [31:0] integ_q, integ_d;
    logic signed [31:0] prev_q, prev_d;
    logic signed [31:0] sp_ua, meas_ua, corr, u_raw;
    logic [15:0]   duty_q, duty_d;
    logic          hi_q, hi_d, lo_q, lo_d;

    assign ctl_on  = cfg_q.enable && OPERATING_MODE == MODE_PWM && !HIGH_SPEED; // RL16
    assign ref_lim = SINGLE_CHANNEL ? REF_MA_SING : REF_MA_DUAL;
    assign ref_ma  = (cfg_q.ref_ma > ref_lim) ? ref_lim : cfg_q.ref_ma;           // RL19
    assign hi_eff  = (cfg_q.hi_lim >= AN_NOMINAL) ? AN_NOMINAL : cfg_q.hi_lim;   // RL21
    // set point and measurement in microamperes of the reference
    assign sp_ua   = 32'((40'(SET_POINT) * 40'(ref_ma) * 40'(UA_PER_MA))
                         / 40'(AN_NOMINAL));
    assign meas_ua = 32'((40'(cur_q) * 40'(ref_ma) * 40'(UA_PER_MA))
                         / 40'(AN_NOMINAL));
    assign err_ua  = sp_ua - meas_ua;
    // signed band edge, so a negative error never compares as a huge unsigned one
    assign dead_s  = signed'(32'(cfg_q.dead_ua));                      // RL20

    always_comb begin
        cfg_d   = PID_CFG_LOAD ? PID_CFG : cfg_q;
        integ_d = integ_q;
        prev_d  = prev_q;
        duty_d  = duty_q;
        hi_d    = hi_q;
        lo_d    = lo_q;
        corr    = '0;
        u_raw   = '0;
        if (!SOFTWARE_RUN_ENABLE || PID_CFG_LOAD || !ctl_on) begin // RL22 RL17
            integ_d = '0;
            prev_d  = '0;
            hi_d    = 1'b0;
            lo_d    = 1'b0;
            duty_d  = ctl_on ? duty_q : SET_POINT;
        end else if (PERIOD_END && valid_q) begin
            if (err_ua > dead_s || err_ua < -dead_s) begin             // RL14 RL20
                integ_d = integ_q + err_ua;
                if (cfg_q.p_sel) corr = corr + (err_ua >>> cfg_q.gain_shift_p);   // RL18
                if (cfg_q.i_sel) corr = corr + (integ_d >>> cfg_q.gain_shift_i);  // RL18
                if (cfg_q.d_sel)
                    corr = corr + ((err_ua - prev_q) >>> cfg_q.gain_shift_d);   // RL18
                prev_d = err_ua;
            end
            u_raw = 32'(duty_q) + corr;                                // RL14
            if (u_raw >= signed'(32'(hi_eff))) begin                   // RL15
                duty_d = hi_eff; hi_d = 1'b1; lo_d = 1'b0;
            end else if (u_raw <= signed'(32'(cfg_q.lo_lim))) begin
                duty_d = cfg_q.lo_lim; hi_d = 1'b0; lo_d = 1'b1;
            end else begin
                duty_d = u_raw[15:0]; hi_d = 1'b0; lo_d = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= '0;
            integ_q <= '0;
            prev_q  <= '0;
            duty_q  <= '0;
            hi_q    <= 1'b0;
            lo_q    <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            integ_q <= integ_d;
            prev_q  <= prev_d;
            duty_q  <= duty_d;
            hi_q    <= hi_d;
            lo_q    <= lo_d;
        end
    end
    assign DUTY_VALUE     = duty_q;                                    // RL15
    assign DUTY_AT_HIGH   = hi_q;
    assign DUTY_AT_LOW    = lo_q;
    assign CONTROL_ACTIVE = ctl_on;

    // ---- checks ----
    a_seq_clear_run: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        !SOFTWARE_RUN_ENABLE |=> seq_q == '0)                          // RL7
        else $error("counter not cleared");
    a_seq_plain_one: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        SOFTWARE_RUN_ENABLE && SEQUENCE_DONE && OPERATING_MODE == MODE_PULSE
        && INPUT_FUNCTION_SETTING == DI_INPUT |=> seq_q == SEQ_W'(SEQ_ONE)) // RL3
        else $error("plain input count not one");
    a_seq_gate_inc: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        SOFTWARE_RUN_ENABLE && SEQUENCE_DONE && OPERATING_MODE == MODE_TRAIN
        && INPUT_FUNCTION_SETTING == DI_HW_GATE
        |=> seq_q == $past(seq_q) + SEQ_W'(SEQ_STEP))                  // RL4
        else $error("gated count not incremented");
    a_seq_pwm_hold: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        SOFTWARE_RUN_ENABLE && OPERATING_MODE == MODE_PWM |=> $stable(seq_q)) // RL6
        else $error("count moved in pwm");
    a_cur_idle_code: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        meas_ok && !OUTPUT_ACTIVE_STATUS |=> cur_q == CUR_IDLE)        // RL9
        else $error("idle code missing");
    a_cur_off_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        !meas_ok |=> cur_q == CUR_NONE)                                // RL8
        else $error("current not zero");
    a_cur_saturate: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        valid_q |-> cur_q <= AN_MAX)                                   // RL23
        else $error("current above ceiling");
    a_duty_limits: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        ctl_on && SOFTWARE_RUN_ENABLE && $past(PERIOD_END && valid_q && ctl_on
        && SOFTWARE_RUN_ENABLE && !PID_CFG_LOAD) |-> duty_q <= AN_NOMINAL)  // RL15
        else $error("duty above limit");
    a_pid_reset: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        PID_CFG_LOAD |=> integ_q == '0 && prev_q == '0)                // RL22
        else $error("controller state kept");

endmodule : psc_top

// file: sim/psc_load_model.sv
// Purpose: load on the pulse output, hands sensed current samples to the channel
// Assumes: one clock shared with the channel, level held by the bench
// Notes:   six samples per 8-cycle period, ripple cancels in the mean
`timescale 1ns/10ps
module psc_load_model (
    input  wire logic        clk,
    input  wire logic        active,
    input  wire logic [23:0] level_ua,
    output logic             sample_valid,
    output logic [23:0]      sample_ua,
    output logic             period_end
);
    localparam logic [23:0] RIPPLE_UA = 24'h0007D0;
    logic [2:0]  phase_q = 3'h0;
    logic [23:0] rip;
    // no ripple on a zero load, so samples never wrap
    assign rip = (level_ua < RIPPLE_UA) ? 24'h0 : RIPPLE_UA;
    // sample then close the window; idle data keeps changing
    always @(posedge clk) begin
        phase_q <= active ? phase_q + 3'h1 : 3'h0;
        sample_valid <= active && (phase_q < 3'h6);
        period_end <= active && (phase_q == 3'h7);
        if (active && phase_q < 3'h6) begin
            sample_ua <= phase_q[0] ? level_ua - rip : level_ua + rip;
        end else begin
            sample_ua <= ~sample_ua;
        end
    end
endmodule : psc_load_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the sequence counter, current report and controller
// Assumes: 25 MHz clock, load model supplies samples and period ends
// Notes:   table rows first, controller cases written by hand after
`timescale 1ns/10ps
module tb_top
    import psc_pkg::*;
;
    typedef struct {psc_mode_t m; psc_difn_t f; int n; logic [3:0] e;} psc_seq_row_t;
    typedef struct {
        psc_mode_t m; logic s, hs, dg; logic [23:0] ua; logic [15:0] e; logic oc;
    } psc_cur_row_t;
    logic         clk = 1'b0, resetn = 1'b0, hs = 1'b0, single = 1'b0, diag = 1'b0;
    logic         run = 1'b1, active = 1'b0, out_a = 1'b0, done = 1'b0, load = 1'b0;
    psc_mode_t    mode = MODE_PULSE;
    psc_difn_t    difn = DI_INPUT;
    psc_pid_cfg_t cfg = '0;
    logic [15:0]  sp = 16'h0000;
    logic [23:0]  level = 24'h0, s_ua;
    logic         s_vld, p_end, oc, d_hi, d_lo, ctl;
    logic [3:0]   cnt;
    logic [15:0]  cur, duty;
    int           err_total = 0, checks_done = 0, cycles = 0, oc_cnt = 0, oc_base, i;
    psc_seq_row_t seq_rows [8] = '{
        '{MODE_PULSE, DI_INPUT, 3, 4'h1}, '{MODE_TRAIN, DI_INPUT, 2, 4'h1},
        '{MODE_PULSE, DI_HW_GATE, 5, 4'h5}, '{MODE_TRAIN, DI_HW_GATE, 17, 4'h1},
        '{MODE_ONOFF, DI_INPUT, 6, 4'h6}, '{MODE_PWM, DI_HW_GATE, 3, 4'h0},
        '{MODE_FREQ, DI_HW_GATE, 3, 4'h0}, '{MODE_MOTOR, DI_HW_GATE, 3, 4'h0}};
    psc_cur_row_t cur_rows [9] = '{
        '{MODE_PWM, 0, 0, 1, 24'h0F4240, 16'h3600, 0},
        '{MODE_PWM, 0, 0, 0, 24'h1E8480, 16'h6C00, 0},
        '{MODE_TRAIN, 1, 0, 1, 24'h3D0900, 16'h6C00, 0},
        '{MODE_PWM, 0, 0, 1, 24'h249F00, 16'h7EFF, 1},
        '{MODE_TRAIN, 1, 0, 1, 24'h44AA20, 16'h7980, 0},
        '{MODE_PWM, 1, 0, 1, 24'h493E00, 16'h7EFF, 1},
        '{MODE_FREQ, 0, 0, 1, 24'h249F00, 16'h0000, 0},
        '{MODE_PWM, 0, 1, 0, 24'h0F4240, 16'h0000, 0},
        '{MODE_PULSE, 0, 0, 0, 24'h0F4240, 16'h0000, 0}};

    psc_top u_psc_top (
        .REF_CLK(clk), .RESETN(resetn), .OPERATING_MODE(mode),
        .INPUT_FUNCTION_SETTING(difn), .HIGH_SPEED(hs), .SINGLE_CHANNEL(single),
        .DIAG_ENABLE(diag), .SOFTWARE_RUN_ENABLE(run), .OUTPUT_ACTIVE_STATUS(active),
        .CHANNEL_OUTPUT_A(out_a), .SEQUENCE_DONE(done), .PERIOD_END(p_end),
        .SAMPLE_VALID(s_vld), .SAMPLE_UA(s_ua), .PID_CFG(cfg), .PID_CFG_LOAD(load),
        .SET_POINT(sp), .COMPLETED_SEQUENCE_COUNT(cnt), .MEASURED_CURRENT(cur),
        .OVERCURRENT(oc), .DUTY_VALUE(duty), .DUTY_AT_HIGH(d_hi), .DUTY_AT_LOW(d_lo),
        .CONTROL_ACTIVE(ctl));
    psc_load_model u_psc_load_model (
        .clk(clk), .active(active), .level_ua(level), .sample_valid(s_vld),
        .sample_ua(s_ua), .period_end(p_end));

    // clock, count of cycles with overcurrent high, and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (oc === 1'b1) oc_cnt++;
        if (cycles == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        // wait 1 ns, then compare got and exp as they were copied at the call, before the wait
        #1;
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic load_cfg(input psc_pid_cfg_t c);
        @(posedge clk) cfg <= c;
        load <= 1'b1;
        @(posedge clk) load <= 1'b0;
    endtask : load_cfg

    task automatic drive(input logic [15:0] s, input logic [23:0] ua, input int n);
        @(posedge clk) sp <= s;
        level <= ua;
        active <= 1'b1;
        repeat (n) @(posedge clk);
    endtask : drive

    initial begin
        repeat (9) @(posedge clk);
        chk({12'h0, cnt}, 16'h0, "count in reset");
        chk(cur, 16'h0, "current in reset");
        @(posedge clk) resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // counter rows: clear by run enable, then count events
        for (i = 0; i < 8; i++) begin
            @(posedge clk) mode <= seq_rows[i].m;
            difn <= seq_rows[i].f;
            run <= 1'b0;
            @(posedge clk) run <= 1'b1;
            repeat (2) @(posedge clk);
            chk({12'h0, cnt}, 16'h0, "count cleared");
            repeat (seq_rows[i].n) begin
                @(posedge clk) if (mode == MODE_ONOFF) out_a <= ~out_a;
                else done <= 1'b1;
                @(posedge clk) done <= 1'b0;
            end
            repeat (2) @(posedge clk);
            chk({12'h0, cnt}, {12'h0, seq_rows[i].e}, "count");
        end
        // current rows: idle code, wait for first period, mean and overcurrent
        for (i = 0; i < 9; i++) begin
            @(posedge clk) mode <= cur_rows[i].m;
            single <= cur_rows[i].s;
            hs <= cur_rows[i].hs;
            diag <= cur_rows[i].dg;
            active <= 1'b0;
            repeat (4) @(posedge clk);
            chk(cur, (cur_rows[i].e == 16'h0) ? CUR_NONE : CUR_IDLE, "idle");
            oc_base = oc_cnt;
            drive(16'h0, cur_rows[i].ua, 3);
            chk(cur, (cur_rows[i].e == 16'h0) ? CUR_NONE : CUR_IDLE, "early");
            repeat (24) @(posedge clk);
            chk(cur, cur_rows[i].e, "mean");
            chk({15'h0, oc_cnt != oc_base}, {15'h0, cur_rows[i].oc}, "ovc");
        end
        // controller: p part only, limits kept high above low
        @(posedge clk) mode <= MODE_PWM;
        hs <= 1'b0;
        single <= 1'b0;
        active <= 1'b0;
        load_cfg('{1, 1, 0, 0, 13'h03E8, 24'h0, 16'h2000, 16'h0400, 0, 0, 0});
        @(posedge clk);
        chk({15'h0, ctl}, 16'h1, "ctl on");
        drive(16'h6C00, 24'h0, 40);
        chk(duty, 16'h2000, "high clamp");
        chk({15'h0, d_hi}, 16'h1, "at high");
        drive(16'h0000, 24'h0F4240, 40);
        chk(duty, 16'h0400, "low clamp");
        chk({15'h0, d_lo}, 16'h1, "at low");
        @(posedge clk) mode <= MODE_FREQ;
        @(posedge clk);
        chk({15'h0, ctl}, 16'h0, "ctl freq");
        @(posedge clk) mode <= MODE_PWM;
        hs <= 1'b1;
        @(posedge clk);
        chk({15'h0, ctl}, 16'h0, "ctl hs");
        @(posedge clk) hs <= 1'b0;
        // disabled controller passes the set point through
        load_cfg('{0, 1, 1, 1, 13'h0FA0, 24'h0, 16'h0100, 16'h0080, 0, 0, 0});
        drive(16'h1234, 24'h0F4240, 20);
        chk(duty, 16'h1234, "bypass");
        chk({15'h0, ctl}, 16'h0, "ctl off");
        // wide dead band, then no parts selected: never driven to high
        @(posedge clk) active <= 1'b0;
        load_cfg('{1, 1, 0, 0, 13'h03E8, 24'hFFFFFF, 16'h2000, 16'h0400, 0, 0, 0});
        drive(16'h6C00, 24'h0, 40);
        chk({15'h0, d_hi}, 16'h0, "dead band");
        @(posedge clk) active <= 1'b0;
        load_cfg('{1, 0, 0, 0, 13'h03E8, 24'h0, 16'h2000, 16'h0400, 0, 0, 0});
        drive(16'h6C00, 24'h0, 40);
        chk({15'h0, d_hi}, 16'h0, "no parts");
        // integral part alone drives a large error to the high limit
        @(posedge clk) active <= 1'b0;
        load_cfg('{1, 0, 1, 0, 13'h03E8, 24'h0, 16'h2000, 16'h0400, 0, 0, 0});
        drive(16'h6C00, 24'h0, 40);
        chk({15'h0, d_hi}, 16'h1, "i part");
        tally_and_finish();
    end
endmodule : tb_top
